// *** hdl/radio_irq_and_slow_clock_cal.sv ***
module radio_irq_and_slow_clock_cal #(
  parameter int GAIN_SWITCH_CYCLES = 100,
  parameter int GP_TIMER_CLOCK_DIV = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic wake_clk_external,
  input wire logic wake_clk_internal,
  input wire logic tx_fifo_write,
  input wire logic tx_fifo_full,
  input wire logic tx_fifo_overflow,
  input wire logic tx_fifo_underrun,
  input wire logic cca_busy_in,
  output logic event_line_n
);

  typedef struct packed {
    logic [23:0] flags;
    logic [23:0] mask;
    logic [7:0] rdata;
    logic line_n;
    logic [7:0] clock_setting_two;
    logic [7:0] sleep_wake_setting;
    logic [15:0] wake_interval;
    logic [7:0] wake_hold_duration;
    logic [7:0] gp_timer_prescale;
    logic [7:0] gp_timer_one_interval;
    logic [7:0] gp_timer_two_interval;
    logic [7:0] cal_divider_setting;
    logic [7:0] cal_period_count;
    logic [15:0] cal_result;
    logic [15:0] tx_length;
    logic [7:0] cca_avg_count;
    logic cca_result;
    radio_irq_pkg::cca_state_t cca_state;
    logic [15:0] cca_cnt;
    logic [7:0] cca_avg_left;
    logic [7:0] gp_base_cnt;
    logic [7:0] gp_pre_cnt;
    logic gp_tick;
    logic [1:0] tmr_run;
    logic [15:0] tmr_one_cnt;
    logic [15:0] tmr_two_cnt;
    logic cal_run;
    logic [5:0] cal_slow_left;
    logic [15:0] cal_count;
    logic [15:0] cal_div_cnt;
    logic [2:0] slow_sync;
    logic slow_prev;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic slow_mux;
  logic slow_rise;
  logic [15:0] cal_div_top;

  // slow clock source select, sampled as a plain input
  assign slow_mux = s_q.sleep_wake_setting[radio_irq_pkg::WAKE_SOURCE_BIT] ? wake_clk_internal
                                                                             : wake_clk_external;
  // edge seen only once the second and third stages agree
  assign slow_rise = (s_q.slow_sync[2] == s_q.slow_sync[1]) && s_q.slow_sync[1] && !s_q.slow_prev;
  // fast clock divider: (halve + 1) * detection divider, zero divider means one
  assign cal_div_top = 16'((32'(s_q.clock_setting_two[radio_irq_pkg::MASTER_HALVE_BIT]) + 1)
                       * (s_q.cal_divider_setting[7:4] == 4'h0 ? 32'd1 : 32'(s_q.cal_divider_setting[7:4])));

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = radio_irq_pkg::RESET_BYTE;

    // slow clock synchroniser
    s_d.slow_sync = {s_q.slow_sync[1:0], slow_mux};
    if (s_q.slow_sync[2] == s_q.slow_sync[1])
    begin
      s_d.slow_prev = s_q.slow_sync[1];
    end

    // host clears flags by writing ones; hardware sets come later and win
    if (reg_write)
    begin
      case (reg_addr)
        radio_irq_pkg::ADDR_EVENT_FLAGS_0: s_d.flags[7:0] = s_q.flags[7:0] & ~reg_wdata;
        radio_irq_pkg::ADDR_EVENT_FLAGS_1: s_d.flags[15:8] = s_q.flags[15:8] & ~reg_wdata;
        radio_irq_pkg::ADDR_EVENT_FLAGS_2:
        begin
          s_d.flags[23:16] = s_q.flags[23:16] & ~reg_wdata;
          if (reg_wdata[radio_irq_pkg::EV_CCA_DONE - 16])
          begin
            s_d.cca_result = 1'b0;
          end
        end
        radio_irq_pkg::ADDR_EVENT_MASK_0: s_d.mask[7:0] = reg_wdata;
        radio_irq_pkg::ADDR_EVENT_MASK_1: s_d.mask[15:8] = reg_wdata;
        radio_irq_pkg::ADDR_EVENT_MASK_2: s_d.mask[23:16] = reg_wdata;
        radio_irq_pkg::ADDR_CLOCK_SETTING_TWO: s_d.clock_setting_two = reg_wdata;
        radio_irq_pkg::ADDR_SLEEP_WAKE_SETTING: s_d.sleep_wake_setting = reg_wdata;
        radio_irq_pkg::ADDR_WAKE_INTERVAL_HIGH: s_d.wake_interval[15:8] = reg_wdata;
        radio_irq_pkg::ADDR_WAKE_INTERVAL_LOW: s_d.wake_interval[7:0] = reg_wdata;
        radio_irq_pkg::ADDR_WAKE_HOLD_DURATION: s_d.wake_hold_duration = reg_wdata;
        radio_irq_pkg::ADDR_GP_TIMER_PRESCALE: s_d.gp_timer_prescale = reg_wdata;
        radio_irq_pkg::ADDR_GP_TIMER_ONE_INTERVAL: s_d.gp_timer_one_interval = reg_wdata;
        radio_irq_pkg::ADDR_GP_TIMER_TWO_INTERVAL: s_d.gp_timer_two_interval = reg_wdata;
        radio_irq_pkg::ADDR_CAL_DIVIDER_SETTING: s_d.cal_divider_setting = reg_wdata;
        radio_irq_pkg::ADDR_CAL_PERIOD_COUNT: s_d.cal_period_count = reg_wdata;
        radio_irq_pkg::ADDR_TX_LENGTH_HIGH:
        begin
          s_d.tx_length[15:8] = reg_wdata;
          if (reg_wdata[7:3] != 5'h00)
          begin
            s_d.flags[radio_irq_pkg::EV_TX_LEN_ERR] = 1'b1;
          end
        end
        radio_irq_pkg::ADDR_TX_LENGTH_LOW:
        begin
          s_d.tx_length[7:0] = reg_wdata;
          if ({s_q.tx_length[15:8], reg_wdata} == 16'h0000 ||
              {s_q.tx_length[15:8], reg_wdata} > 16'(radio_irq_pkg::TX_LENGTH_MAX))
          begin
            s_d.flags[radio_irq_pkg::EV_TX_LEN_ERR] = 1'b1;
          end
        end
        radio_irq_pkg::ADDR_CCA_SETTING: s_d.cca_avg_count = reg_wdata;
        radio_irq_pkg::ADDR_CONTROL:
        begin
          if (reg_wdata[radio_irq_pkg::CTL_TIMER_ONE_START])
          begin
            s_d.tmr_run[0] = 1'b1;
            s_d.tmr_one_cnt = 16'h0000;
          end
          if (reg_wdata[radio_irq_pkg::CTL_TIMER_TWO_START])
          begin
            s_d.tmr_run[1] = 1'b1;
            s_d.tmr_two_cnt = 16'h0000;
          end
          if (reg_wdata[radio_irq_pkg::CTL_CAL_START])
          begin
            s_d.cal_run = 1'b1;
            s_d.cal_slow_left = s_q.cal_period_count[5:0];
            s_d.cal_count = 16'h0000;
            s_d.cal_div_cnt = 16'h0000;
          end
          if (reg_wdata[radio_irq_pkg::CTL_CCA_START] && s_q.cca_state == radio_irq_pkg::CCA_IDLE)
          begin
            s_d.cca_state = radio_irq_pkg::CCA_AVERAGE;
            s_d.cca_avg_left = s_q.cca_avg_count;
            s_d.cca_cnt = 16'h0000;
            s_d.cca_result = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // register read data, one cycle after the strobe
    if (reg_read)
    begin
      case (reg_addr)
        radio_irq_pkg::ADDR_EVENT_FLAGS_0: s_d.rdata = s_q.flags[7:0];
        radio_irq_pkg::ADDR_EVENT_FLAGS_1: s_d.rdata = s_q.flags[15:8];
        radio_irq_pkg::ADDR_EVENT_FLAGS_2: s_d.rdata = s_q.flags[23:16];
        radio_irq_pkg::ADDR_EVENT_MASK_0: s_d.rdata = s_q.mask[7:0];
        radio_irq_pkg::ADDR_EVENT_MASK_1: s_d.rdata = s_q.mask[15:8];
        radio_irq_pkg::ADDR_EVENT_MASK_2: s_d.rdata = s_q.mask[23:16];
        radio_irq_pkg::ADDR_CLOCK_SETTING_TWO: s_d.rdata = s_q.clock_setting_two;
        radio_irq_pkg::ADDR_SLEEP_WAKE_SETTING: s_d.rdata = s_q.sleep_wake_setting;
        radio_irq_pkg::ADDR_WAKE_INTERVAL_HIGH: s_d.rdata = s_q.wake_interval[15:8];
        radio_irq_pkg::ADDR_WAKE_INTERVAL_LOW: s_d.rdata = s_q.wake_interval[7:0];
        radio_irq_pkg::ADDR_WAKE_HOLD_DURATION: s_d.rdata = s_q.wake_hold_duration;
        radio_irq_pkg::ADDR_GP_TIMER_PRESCALE: s_d.rdata = s_q.gp_timer_prescale;
        radio_irq_pkg::ADDR_GP_TIMER_ONE_INTERVAL: s_d.rdata = s_q.gp_timer_one_interval;
        radio_irq_pkg::ADDR_GP_TIMER_TWO_INTERVAL: s_d.rdata = s_q.gp_timer_two_interval;
        radio_irq_pkg::ADDR_CAL_DIVIDER_SETTING: s_d.rdata = s_q.cal_divider_setting;
        radio_irq_pkg::ADDR_CAL_PERIOD_COUNT: s_d.rdata = s_q.cal_period_count;
        radio_irq_pkg::ADDR_CAL_RESULT_HIGH: s_d.rdata = s_q.cal_result[15:8];
        radio_irq_pkg::ADDR_CAL_RESULT_LOW: s_d.rdata = s_q.cal_result[7:0];
        radio_irq_pkg::ADDR_TX_LENGTH_HIGH: s_d.rdata = s_q.tx_length[15:8];
        radio_irq_pkg::ADDR_TX_LENGTH_LOW: s_d.rdata = s_q.tx_length[7:0];
        radio_irq_pkg::ADDR_CONTROL: s_d.rdata = {4'h0, s_q.cca_state != radio_irq_pkg::CCA_IDLE,
                                                  s_q.cal_run, s_q.tmr_run};
        radio_irq_pkg::ADDR_CCA_SETTING: s_d.rdata = s_q.cca_avg_count;
        radio_irq_pkg::ADDR_CCA_RESULT: s_d.rdata = {7'h00, s_q.cca_result};
        default: s_d.rdata = radio_irq_pkg::RESET_BYTE;
      endcase
    end

    // transmit fifo access errors
    if ((tx_fifo_write && tx_fifo_full) || tx_fifo_overflow || tx_fifo_underrun)
    begin
      s_d.flags[radio_irq_pkg::EV_TX_FIFO_ERR] = 1'b1;
    end

    // shared timer clock: base divider then prescale ratio
    s_d.gp_tick = 1'b0;
    if (s_q.gp_base_cnt == 8'(GP_TIMER_CLOCK_DIV - 1))
    begin
      s_d.gp_base_cnt = 8'h00;
      if (s_q.gp_pre_cnt >= s_q.gp_timer_prescale)
      begin
        s_d.gp_pre_cnt = 8'h00;
        s_d.gp_tick = 1'b1;
      end
      else
      begin
        s_d.gp_pre_cnt = s_q.gp_pre_cnt + 8'h01;
      end
    end
    else
    begin
      s_d.gp_base_cnt = s_q.gp_base_cnt + 8'h01;
    end

    // a start from idle restarts the shared divider so no tick arrives early
    if (reg_write && reg_addr == radio_irq_pkg::ADDR_CONTROL && s_q.tmr_run == 2'b00 &&
        (reg_wdata[radio_irq_pkg::CTL_TIMER_ONE_START] || reg_wdata[radio_irq_pkg::CTL_TIMER_TWO_START]))
    begin
      s_d.gp_base_cnt = 8'h00;
      s_d.gp_pre_cnt = 8'h00;
      s_d.gp_tick = 1'b0;
    end

    // general purpose timers
    if (s_q.tmr_run[0] && s_q.gp_tick)
    begin
      s_d.tmr_one_cnt = s_q.tmr_one_cnt + 16'h0001;
      if (s_d.tmr_one_cnt >= {8'h00, s_q.gp_timer_one_interval})
      begin
        s_d.tmr_run[0] = 1'b0;
        s_d.flags[radio_irq_pkg::EV_TIMER_ONE] = 1'b1;
      end
    end
    if (s_q.tmr_run[1] && s_q.gp_tick)
    begin
      s_d.tmr_two_cnt = s_q.tmr_two_cnt + 16'h0001;
      if (s_d.tmr_two_cnt >= {8'h00, s_q.gp_timer_two_interval})
      begin
        s_d.tmr_run[1] = 1'b0;
        s_d.flags[radio_irq_pkg::EV_TIMER_TWO] = 1'b1;
      end
    end

    // calibration: divided fast clock counted across slow periods
    if (s_q.cal_run)
    begin
      if (s_q.cal_div_cnt + 16'h0001 >= cal_div_top)
      begin
        s_d.cal_div_cnt = 16'h0000;
        s_d.cal_count = s_q.cal_count + 16'h0001;
      end
      else
      begin
        s_d.cal_div_cnt = s_q.cal_div_cnt + 16'h0001;
      end
      if (slow_rise)
      begin
        if (s_q.cal_slow_left <= 6'h01)
        begin
          s_d.cal_run = 1'b0;
          s_d.cal_result = s_q.cal_count;
          s_d.flags[radio_irq_pkg::EV_CAL_DONE] = 1'b1;
        end
        else
        begin
          s_d.cal_slow_left = s_q.cal_slow_left - 6'h01;
        end
      end
    end

    // busy-detection CCA: averaging windows then gain switching
    case (s_q.cca_state)
      radio_irq_pkg::CCA_IDLE: ;
      radio_irq_pkg::CCA_AVERAGE:
      begin
        if (cca_busy_in)
        begin
          s_d.cca_result = 1'b1;
        end
        if (s_q.cca_avg_left == 8'h00)
        begin
          s_d.cca_state = radio_irq_pkg::CCA_GAIN;
          s_d.cca_cnt = 16'h0000;
        end
        else if (s_q.cca_cnt == 16'(radio_irq_pkg::CCA_AVG_CYCLES - 1))
        begin
          s_d.cca_cnt = 16'h0000;
          s_d.cca_avg_left = s_q.cca_avg_left - 8'h01;
        end
        else
        begin
          s_d.cca_cnt = s_q.cca_cnt + 16'h0001;
        end
      end
      radio_irq_pkg::CCA_GAIN:
      begin
        if (s_q.cca_cnt >= 16'(GAIN_SWITCH_CYCLES - 1))
        begin
          s_d.cca_state = radio_irq_pkg::CCA_IDLE;
          s_d.flags[radio_irq_pkg::EV_CCA_DONE] = 1'b1;
        end
        else
        begin
          s_d.cca_cnt = s_q.cca_cnt + 16'h0001;
        end
      end
      default: s_d.cca_state = radio_irq_pkg::CCA_IDLE;
    endcase

    // flags unused here stay clear; masked flags still recorded
    s_d.flags = s_d.flags & radio_irq_pkg::EVENTS_USED;
    s_d.line_n = ~|(s_d.flags & s_d.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.line_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign event_line_n = s_q.line_n;

endmodule // radio_irq_and_slow_clock_cal

// *** hdl/radio_irq_pkg.sv ***
package radio_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_FLAGS_0 = 8'h0D;
  localparam logic [7:0] ADDR_EVENT_FLAGS_1 = 8'h0E;
  localparam logic [7:0] ADDR_EVENT_FLAGS_2 = 8'h0F;
  localparam logic [7:0] ADDR_EVENT_MASK_0 = 8'h10;
  localparam logic [7:0] ADDR_EVENT_MASK_1 = 8'h11;
  localparam logic [7:0] ADDR_EVENT_MASK_2 = 8'h12;
  localparam logic [7:0] ADDR_CLOCK_SETTING_TWO = 8'h02;
  localparam logic [7:0] ADDR_SLEEP_WAKE_SETTING = 8'h2D;
  localparam logic [7:0] ADDR_WAKE_INTERVAL_HIGH = 8'h2F;
  localparam logic [7:0] ADDR_WAKE_INTERVAL_LOW = 8'h30;
  localparam logic [7:0] ADDR_WAKE_HOLD_DURATION = 8'h31;
  localparam logic [7:0] ADDR_GP_TIMER_PRESCALE = 8'h33;
  localparam logic [7:0] ADDR_GP_TIMER_ONE_INTERVAL = 8'h34;
  localparam logic [7:0] ADDR_GP_TIMER_TWO_INTERVAL = 8'h35;
  localparam logic [7:0] ADDR_CAL_DIVIDER_SETTING = 8'h70;
  localparam logic [7:0] ADDR_CAL_PERIOD_COUNT = 8'h71;
  localparam logic [7:0] ADDR_CAL_RESULT_HIGH = 8'h72;
  localparam logic [7:0] ADDR_CAL_RESULT_LOW = 8'h73;
  localparam logic [7:0] ADDR_TX_LENGTH_HIGH = 8'h7A;
  localparam logic [7:0] ADDR_TX_LENGTH_LOW = 8'h7B;
  localparam logic [7:0] ADDR_CONTROL = 8'hE0;
  localparam logic [7:0] ADDR_CCA_SETTING = 8'hE1;
  localparam logic [7:0] ADDR_CCA_RESULT = 8'hE2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EV_CAL_DONE = 7;
  localparam int EV_CCA_DONE = 18;
  localparam int EV_TX_LEN_ERR = 19;
  localparam int EV_TX_FIFO_ERR = 20;
  localparam int EV_TIMER_ONE = 22;
  localparam int EV_TIMER_TWO = 23;
  localparam int CTL_TIMER_ONE_START = 0;
  localparam int CTL_TIMER_TWO_START = 1;
  localparam int CTL_CAL_START = 2;
  localparam int CTL_CCA_START = 3;
  localparam int MASTER_HALVE_BIT = 5;
  localparam int WAKE_SOURCE_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [23:0] RESET_EVENTS = 24'h00_0000;
  localparam logic [23:0] EVENTS_USED = 24'hDC_0080;
  localparam int CLK_HZ = 50_000_000;
  localparam int CCA_AVG_US = 16;
  localparam int CCA_AVG_CYCLES = CCA_AVG_US * (CLK_HZ / 1_000_000);
  localparam logic [10:0] TX_LENGTH_MAX = 11'h7FF;

  typedef enum logic [1:0] {
    CCA_IDLE = 2'b00,
    CCA_AVERAGE = 2'b01,
    CCA_GAIN = 2'b10
  } cca_state_t;

endpackage

// *** tb/radio_irq_and_slow_clock_cal_tb_top.sv ***
// ----------------------------------------
// bench for event flags and slow clock calibration
// ----------------------------------------
module radio_irq_and_slow_clock_cal_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAIN = 10;
  localparam int TDIV = 4;
  localparam int EXT_HALF = 1003;
  localparam int INT_HALF = 1507;
  logic clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, cca_busy_in = 1'b0;
  logic tx_fifo_write = 1'b0, tx_fifo_full = 1'b0, tx_fifo_overflow = 1'b0, tx_fifo_underrun = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic event_line_n, wake_clk_external, wake_clk_internal;
  int n_fail = 0, total_checks = 0, cycles = 0;
  radio_irq_and_slow_clock_cal #(.GAIN_SWITCH_CYCLES(GAIN), .GP_TIMER_CLOCK_DIV(TDIV)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .wake_clk_external(wake_clk_external),
    .wake_clk_internal(wake_clk_internal), .tx_fifo_write(tx_fifo_write), .tx_fifo_full(tx_fifo_full),
    .tx_fifo_overflow(tx_fifo_overflow), .tx_fifo_underrun(tx_fifo_underrun), .cca_busy_in(cca_busy_in),
    .event_line_n(event_line_n));
  radio_wake_clock_model #(.EXT_HALF_NS(EXT_HALF), .INT_HALF_NS(INT_HALF)) u_wake (
    .wake_clk_external(wake_clk_external), .wake_clk_internal(wake_clk_internal));
  always #10 clk = ~clk;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // waits a bounded number of cycles for the line to go low
  task automatic wait_low(input int max, output int n);
    n = 0;
    #1;
    while (event_line_n !== 1'b0 && n < max)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, event_line_n}, 8'h00);
  endtask
  // one fifo event: 0 write when full, 1 overflow, 2 underrun, 3 plain write
  task automatic fifo_ev(input int k);
    @(posedge clk);
    tx_fifo_write <= (k == 0 || k == 3);
    tx_fifo_full <= (k == 0);
    tx_fifo_overflow <= (k == 1);
    tx_fifo_underrun <= (k == 2);
    @(posedge clk);
    {tx_fifo_write, tx_fifo_full, tx_fifo_overflow, tx_fifo_underrun} <= 4'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    int n;
    int e;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] ra [8];
    ra = '{8'h2F, 8'h30, 8'h31, 8'h33, 8'h34, 8'h35, 8'h70, 8'h71};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({7'h00, event_line_n}, 8'h01);
    foreach (ra[i])
      rdchk(ra[i], 8'h00);
    foreach (ra[i])
      wr(ra[i], ra[i] ^ 8'h5A);
    foreach (ra[i])
      rdchk(ra[i], ra[i] ^ 8'h5A);
    wr(8'h72, 8'hFF);
    wr(8'hFF, 8'hFF);
    rdchk(8'h72, 8'h00);
    rdchk(8'hFF, 8'h00);
    wr(8'h30, 8'h0D);
    rdchk(8'h30, 8'h0D);
    $display("test registers done");
    wr(8'h7A, 8'h08);
    rdchk(8'h0F, 8'h08);
    chk({7'h00, event_line_n}, 8'h01);
    wr(8'h12, 8'h08);
    wait_low(4, n);
    wr(8'h7A, 8'h07);
    rdchk(8'h0F, 8'h08);
    wr(8'h0F, 8'h08);
    rdchk(8'h0F, 8'h00);
    chk({7'h00, event_line_n}, 8'h01);
    wr(8'h7A, 8'h00);
    wr(8'h7B, 8'h10);
    rdchk(8'h0F, 8'h00);
    wr(8'h7B, 8'h00);
    rdchk(8'h0F, 8'h08);
    wr(8'h0F, 8'h08);
    wr(8'h7A, 8'h10);
    rdchk(8'h0F, 8'h08);
    chk({7'h00, event_line_n}, 8'h00);
    wr(8'h0F, 8'h08);
    wr(8'h7A, 8'h00);
    $display("test length done");
    wr(8'h0D, 8'h30);
    wr(8'h0E, 8'h13);
    rdchk(8'h0D, 8'h00);
    rdchk(8'h0E, 8'h00);
    wr(8'h12, 8'h10);
    rdchk(8'h12, 8'h10);
    fifo_ev(3);
    rdchk(8'h0F, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      fifo_ev(k);
      rdchk(8'h0F, (k < 3) ? 8'h10 : 8'h00);
      chk({7'h00, event_line_n}, (k < 3) ? 8'h00 : 8'h01);
      wr(8'h0F, 8'h10);
    end
    $display("test fifo done");
    wr(8'h12, 8'h04);
    wr(8'hE1, 8'h02);
    cca_busy_in <= 1'b1;
    wr(8'hE0, 8'h08);
    wait_low(2000, n);
    chk_rng(n[15:0], 2 * 16 * 50 + GAIN, 2 * 16 * 50 + GAIN + 4);
    rdchk(8'hE2, 8'h01);
    wr(8'h0F, 8'h04);
    rdchk(8'hE2, 8'h00);
    cca_busy_in <= 1'b0;
    $display("test cca done");
    wr(8'h33, 8'h01);
    for (int t = 0; t < 2; t++)
    begin
      wr(8'(8'h34 + t), 8'(3 + 2 * t));
      wr(8'h12, 8'h40 << t);
      wr(8'hE0, 8'h01 << t);
      wait_low(200, n);
      chk_rng(n[15:0], TDIV * 2 * (3 + 2 * t), TDIV * 2 * (3 + 2 * t) + 5);
      wr(8'h0F, 8'h40 << t);
    end
    $display("test timers done");
    wr(8'h12, 8'h00);
    wr(8'h10, 8'h80);
    for (int c = 0; c < 2; c++)
    begin
      wr(8'h2D, c ? 8'h04 : 8'h00);
      wr(8'h02, c ? 8'h20 : 8'h00);
      wr(8'h70, c ? 8'h20 : 8'h10);
      wr(8'h71, c ? 8'h02 : 8'h04);
      if (c)
        @(negedge wake_clk_internal);
      else
        @(negedge wake_clk_external);
      wr(8'hE0, 8'h04);
      rdchk(8'hE0, 8'h04);
      wait_low(1000, n);
      rd(8'h72, hi);
      rd(8'h73, lo);
      e = c ? 3 * INT_HALF / 20 / 4 : 7 * EXT_HALF / 20;
      chk_rng({hi, lo}, e - 8, e + 8);
      wr(8'h0D, 8'h80);
    end
    $display("test calibration done");
    end_sim();
  end
  // cuts a hung run short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
endmodule // radio_irq_and_slow_clock_cal_tb_top

// *** tb/radio_irq_sva.sv ***
// ----------------------------------------
// event line checker
// ----------------------------------------
module radio_irq_sva #(
  parameter int GAIN_SWITCH_CYCLES = 100,
  parameter int GP_TIMER_CLOCK_DIV = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic wake_clk_external,
  input wire logic wake_clk_internal,
  input wire logic tx_fifo_write,
  input wire logic tx_fifo_full,
  input wire logic tx_fifo_overflow,
  input wire logic tx_fifo_underrun,
  input wire logic cca_busy_in,
  input wire logic event_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  // shadow of mask bytes 0x12 (upper) and 0x10 (lower), the only groups with events
  always_comb
  begin
    mask_d = mask_q;
    if (reg_write && reg_addr == 8'h12)
      mask_d[15:8] = reg_wdata;
    if (reg_write && reg_addr == 8'h10)
      mask_d[7:0] = reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= 16'h0000;
    else
      mask_q <= mask_d;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // clear of the cca flag, then a read of the cca result
  sequence s_cca_clear;
    reg_write && reg_addr == 8'h0F && reg_wdata[2];
  endsequence
  sequence s_cca_read;
    reg_read && reg_addr == 8'hE2;
  endsequence
  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  property p_unmapped_read;
    $past(reg_read) && $past(reg_addr) == 8'hFF |-> reg_rdata == 8'h00;
  endproperty
  property p_len_err;
    reg_write && reg_addr == 8'h7A && reg_wdata[7:3] != 5'h00 && mask_q[11] |-> ##[1:4] !event_line_n;
  endproperty
  property p_fifo_err;
    (tx_fifo_write && tx_fifo_full || tx_fifo_overflow || tx_fifo_underrun) && mask_q[12]
      |-> ##[1:4] !event_line_n;
  endproperty
  property p_line_holds;
    !event_line_n && !reg_write && !$past(reg_write) |=> !event_line_n;
  endproperty
  property p_line_release;
    $rose(event_line_n) |-> $past(reg_write);
  endproperty
  property p_line_cause;
    $fell(event_line_n) |-> mask_q != 16'h0000;
  endproperty
  property p_cca_clear;
    s_cca_clear ##[1:2] s_cca_read |=> reg_rdata[0] == 1'b0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  a_len_err: assert property (p_len_err) else $error("length error not signalled");
  a_fifo_err: assert property (p_fifo_err) else $error("fifo error not signalled");
  a_line_holds: assert property (p_line_holds) else $error("line released without write");
  a_line_release: assert property (p_line_release) else $error("line rose without write");
  a_line_cause: assert property (p_line_cause) else $error("line fell with all masked");
  a_cca_clear: assert property (p_cca_clear) else $error("cca result kept after clear");
endmodule // radio_irq_sva

bind radio_irq_and_slow_clock_cal radio_irq_sva #(
  .GAIN_SWITCH_CYCLES(GAIN_SWITCH_CYCLES), .GP_TIMER_CLOCK_DIV(GP_TIMER_CLOCK_DIV)) u_sva (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .wake_clk_external(wake_clk_external),
  .wake_clk_internal(wake_clk_internal), .tx_fifo_write(tx_fifo_write), .tx_fifo_full(tx_fifo_full),
  .tx_fifo_overflow(tx_fifo_overflow), .tx_fifo_underrun(tx_fifo_underrun), .cca_busy_in(cca_busy_in),
  .event_line_n(event_line_n));

// *** tb/radio_wake_clock_model.sv ***
// ----------------------------------------
// slow wake clock sources
// ----------------------------------------
module radio_wake_clock_model #(
  parameter int EXT_HALF_NS = 1003,
  parameter int INT_HALF_NS = 1507
) (
  output logic wake_clk_external,
  output logic wake_clk_internal
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running oscillators, not locked to clk; every tenth edge of each lands on a multiple of 10 ns, a clk edge
  initial
  begin
    wake_clk_external = 1'b0;
    wake_clk_internal = 1'b0;
  end
  always #(EXT_HALF_NS) wake_clk_external = ~wake_clk_external;
  always #(INT_HALF_NS) wake_clk_internal = ~wake_clk_internal;
endmodule // radio_wake_clock_model
